// >>> inc/pla_pkg.sv
// constants and types shared by the position loop and its modulo tracker
// assumes a single 125 mhz clock and synchronous active-low reset
package pla_pkg;

    // position word width, two's complement counts
    localparam int POS_W = 32;
    // proportional gain width and its binary point
    localparam int KP_W = 16;
    localparam int KP_SHIFT = 8;

    // operating mode selector value that enables the loop
    localparam logic [3:0] OPMODE_POSITION = 4'h2;
    // digital output modes comparing against a threshold
    localparam logic [3:0] DOUT_MODE_ABOVE = 4'h5;
    localparam logic [3:0] DOUT_MODE_BELOW = 4'h6;

    // clock period and loop sample period, in ns
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int LOOP_PERIOD_NS = 1000;
    // loop period rounded down to whole clock cycles, never below one
    localparam int LOOP_CYCLES_RAW = LOOP_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int LOOP_CYCLES = (LOOP_CYCLES_RAW < 1) ? 1 : LOOP_CYCLES_RAW;
    localparam int TICK_W = 8;

    // reset values of status state
    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
    localparam logic [TICK_W-1:0] TICK_RESET = 8'h00;

    // absolute move direction choices with modulo enabled
    typedef enum logic [1:0] {
        PLA_DIR_POS,
        PLA_DIR_NEG,
        PLA_DIR_SHORT,
        PLA_DIR_INSIDE
    } pla_dir_t;

    // motion generator state
    typedef enum logic {
        PLA_MV_IDLE,
        PLA_MV_RUN
    } pla_move_t;

endpackage : pla_pkg

// >>> rtl/pla_modtrack.sv
// incremental modulo position tracker: accumulates a delta and folds the
// result into [range_lo, range_hi) one range per cycle
// assumes each delta is smaller than one modulo range
`timescale 1ns/1ps
module pla_modtrack
    import pla_pkg::*;
#(
    parameter int W = POS_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic mod_active,
    input wire logic signed [W-1:0] range_lo,
    input wire logic signed [W-1:0] range_hi,
    input wire logic load,
    input wire logic signed [W-1:0] load_value,
    input wire logic signed [W-1:0] delta,
    output logic signed [W-1:0] value,
    output logic settled
);

    logic signed [W-1:0] value_r; // tracked position
    logic signed [W-1:0] sum; // raw next position
    logic signed [W-1:0] range_w; // modulo range length
    logic signed [W-1:0] value_nxt; // folded next position

    assign range_w = range_hi - range_lo;
    assign sum = load ? load_value : value_r + delta;
    // a far-away load value takes several cycles to fold in
    assign value_nxt = !mod_active ? sum
                     : (sum >= range_hi) ? sum - range_w
                     : (sum < range_lo) ? sum + range_w
                     : sum;
    assign settled = !mod_active
                   || (value_r >= range_lo && value_r < range_hi);
    assign value = value_r;

    // position register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            value_r <= POS_RESET;
        end else begin
            value_r <= value_nxt;
        end
    end

endmodule : pla_modtrack

// >>> rtl/pla_position_loop.sv
// position loop with following-error check and a modulo axis feature
// assumes feedback, commands and settings are synchronous to clock
`timescale 1ns/1ps

// What this block does
// - loop runs only in position mode
// - excess position error raises following fault
// - zero error limit disables the fault
// - loop applies proportional gain only
// - command, feedback, error, velocity are readable
// - modulo position wraps to range start
// - lower bound starts range, other ends
// - four direction choices for absolute moves
// - actual and commanded positions read modulo
// - both capture positions read modulo
// - software limit past threshold stops motion
// - limit outside modulo range never stops
// - limit flag true inside its window
// - window outside modulo range never active
// - output modes above and below threshold
// - out-of-range threshold gives constant output once the position is folded into range
// - absolute targets are taken as modulo values
// - out-of-range absolute target raises warning
// - actual position loaded from feedback at startup
module pla_position_loop
    import pla_pkg::*;
#(
    parameter int NUM_PLS = 4,
    parameter int NUM_DOUT = 2,
    parameter int LOOP_DIV = LOOP_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] operating_mode_select,
    input wire logic [KP_W-1:0] position_prop_gain,
    input wire logic [POS_W-1:0] max_following_error,
    input wire logic following_error_clear,
    input wire logic modulo_enable,
    input wire logic signed [POS_W-1:0] modulo_bound_a,
    input wire logic signed [POS_W-1:0] modulo_bound_b,
    input wire logic [1:0] absolute_move_direction,
    input wire logic signed [POS_W-1:0] feedback_position,
    input wire logic feedback_valid,
    input wire logic move_start,
    input wire logic signed [POS_W-1:0] move_target,
    input wire logic [POS_W-2:0] move_step,
    input wire logic signed [POS_W-1:0] sw_limit_pos,
    input wire logic signed [POS_W-1:0] sw_limit_neg,
    input wire logic [1:0] capture_trigger,
    input wire logic [NUM_PLS*POS_W-1:0] pls_low,
    input wire logic [NUM_PLS*POS_W-1:0] pls_high,
    input wire logic [NUM_DOUT*4-1:0] dout_mode,
    input wire logic [NUM_DOUT*POS_W-1:0] dout_threshold,
    output logic signed [POS_W-1:0] commanded_position,
    output logic signed [POS_W-1:0] actual_position,
    output logic signed [POS_W-1:0] position_error_value,
    output logic signed [POS_W-1:0] velocity_command,
    output logic signed [POS_W-1:0] capture_a_position,
    output logic signed [POS_W-1:0] capture_b_position,
    output logic following_error_fault,
    output logic move_target_warning,
    output logic move_busy,
    output logic sw_limit_hit,
    output logic position_loaded,
    output logic [NUM_PLS-1:0] pls_flag,
    output logic [NUM_DOUT-1:0] dout_level
);

    // true when x lies inside the active modulo range, or modulo is off
    function automatic logic in_mod(
        input logic signed [POS_W-1:0] x,
        input logic signed [POS_W-1:0] lo,
        input logic signed [POS_W-1:0] hi,
        input logic active
    );
        return !active || (x >= lo && x < hi);
    endfunction : in_mod

    // loop sample divider
    logic [TICK_W-1:0] tick_cnt_r; // cycles since last tick
    logic tick; // one-cycle loop enable
    assign tick = (tick_cnt_r == TICK_W'(LOOP_DIV - 1));

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tick_cnt_r <= TICK_RESET;
        end else begin
            tick_cnt_r <= tick ? TICK_RESET : tick_cnt_r + 8'h01;
        end
    end

    // modulo range from the two bounds, whichever is lower starts it
    logic signed [POS_W-1:0] range_lo; // range start
    logic signed [POS_W-1:0] range_hi; // range end, exclusive
    logic signed [POS_W-1:0] range_len; // range length
    logic mod_active; // modulo on with a non-empty range
    assign range_lo = (modulo_bound_a < modulo_bound_b)
                    ? modulo_bound_a : modulo_bound_b;
    assign range_hi = (modulo_bound_a < modulo_bound_b)
                    ? modulo_bound_b : modulo_bound_a;
    assign range_len = range_hi - range_lo;
    // equal bounds would give a zero range, so modulo then stays off
    assign mod_active = modulo_enable && (range_hi > range_lo);

    // linear positions used by the loop; modulo copies for reporting, limits and move planning
    logic signed [POS_W-1:0] fb_lin_r; // linear feedback
    logic signed [POS_W-1:0] cmd_lin_r; // linear command
    logic loaded_r; // first feedback word taken
    logic fb_load; // power-up load of the feedback word
    logic signed [POS_W-1:0] fb_delta; // feedback change this cycle
    assign fb_load = feedback_valid && !loaded_r;
    assign fb_delta = (feedback_valid && loaded_r)
                    ? feedback_position - fb_lin_r : POS_RESET;

    // motion generator signals
    pla_move_t move_state_r; // idle or running
    logic signed [POS_W-1:0] remain_r; // distance still to travel
    logic signed [POS_W-1:0] step_max; // step limit per tick
    logic signed [POS_W-1:0] step; // this tick's step
    logic signed [POS_W-1:0] cmd_delta; // command change this cycle
    logic moving_tick; // a step is applied now
    assign step_max = $signed({1'b0, move_step});
    assign step = (remain_r > step_max) ? step_max
                : (remain_r < -step_max) ? -step_max
                : remain_r;
    assign moving_tick = tick && (move_state_r == PLA_MV_RUN);
    assign cmd_delta = moving_tick ? step : POS_RESET;

    // modulo trackers for the reported positions
    logic signed [POS_W-1:0] act_disp; // reported actual position
    logic signed [POS_W-1:0] cmd_disp; // reported commanded position
    logic act_settled; // actual copy folded into range
    logic cmd_settled; // command copy folded into range

    pla_modtrack #(.W(POS_W)) u_act_track (
        .clock(clock),
        .rst_n(rst_n),
        .mod_active(mod_active),
        .range_lo(range_lo),
        .range_hi(range_hi),
        .load(fb_load),
        .load_value(feedback_position),
        .delta(fb_delta),
        .value(act_disp),
        .settled(act_settled)
    );

    pla_modtrack #(.W(POS_W)) u_cmd_track (
        .clock(clock),
        .rst_n(rst_n),
        .mod_active(mod_active),
        .range_lo(range_lo),
        .range_hi(range_hi),
        .load(fb_load),
        .load_value(feedback_position),
        .delta(cmd_delta),
        .value(cmd_disp),
        .settled(cmd_settled)
    );

    assign actual_position = act_disp;
    assign commanded_position = cmd_disp;
    assign position_loaded = loaded_r;

    // feedback and command registers; command starts at the feedback
    // value so the loop does not jump at power-up
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fb_lin_r <= POS_RESET;
            cmd_lin_r <= POS_RESET;
            loaded_r <= 1'b0;
        end else begin
            if (feedback_valid) begin
                fb_lin_r <= feedback_position;
            end
            if (fb_load) begin
                cmd_lin_r <= feedback_position;
            end else begin
                cmd_lin_r <= cmd_lin_r + cmd_delta;
            end
            loaded_r <= loaded_r || feedback_valid;
        end
    end

    // absolute move planning; targets are modulo values when on
    logic target_bad; // target outside the modulo range
    logic signed [POS_W-1:0] d_raw; // target minus reported command
    logic signed [POS_W-1:0] d_pos; // positive-going distance
    logic signed [POS_W-1:0] d_neg; // negative-going distance
    logic signed [POS_W-1:0] d_mod; // distance for the chosen direction
    logic signed [POS_W-1:0] move_dist; // planned distance
    pla_dir_t dir_sel; // chosen direction
    assign dir_sel = pla_dir_t'(absolute_move_direction);
    assign target_bad = !in_mod(move_target, range_lo, range_hi,
                                mod_active);
    assign d_raw = move_target - cmd_disp;
    assign d_pos = (d_raw < 0) ? d_raw + range_len : d_raw;
    assign d_neg = (d_pos == 0) ? POS_RESET : d_pos - range_len;
    assign d_mod = (dir_sel == PLA_DIR_POS) ? d_pos
                 : (dir_sel == PLA_DIR_NEG) ? d_neg
                 : (dir_sel == PLA_DIR_SHORT)
                   ? ((-d_neg < d_pos) ? d_neg : d_pos)
                 : d_raw;
    assign move_dist = mod_active ? d_mod : move_target - cmd_lin_r;

    // software limits; in modulo space a threshold outside the range
    // is never reached, so it is simply ignored
    logic lim_pos_ok; // positive threshold usable
    logic lim_neg_ok; // negative threshold usable
    logic lim_hit; // actual position beyond a usable threshold
    assign lim_pos_ok = in_mod(sw_limit_pos, range_lo, range_hi,
                               mod_active);
    assign lim_neg_ok = in_mod(sw_limit_neg, range_lo, range_hi,
                               mod_active);
    assign lim_hit = loaded_r && act_settled
                   && ((lim_pos_ok && act_disp > sw_limit_pos)
                       || (lim_neg_ok && act_disp < sw_limit_neg));
    assign sw_limit_hit = lim_hit;
    assign move_busy = (move_state_r == PLA_MV_RUN);

    // motion generator; a limit hit aborts the move and holds command
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            move_state_r <= PLA_MV_IDLE;
            remain_r <= POS_RESET;
            move_target_warning <= 1'b0;
        end else begin
            move_target_warning <= move_start && target_bad;
            case (move_state_r)
                PLA_MV_IDLE: begin
                    if (move_start && !target_bad && loaded_r && !lim_hit) begin
                        move_state_r <= PLA_MV_RUN;
                        remain_r <= move_dist;
                    end
                end
                PLA_MV_RUN: begin
                    if (lim_hit) begin
                        move_state_r <= PLA_MV_IDLE;
                        remain_r <= POS_RESET;
                    end else if (move_start && !target_bad) begin
                        // a step taken this cycle is already in the plan
                        remain_r <= move_dist - cmd_delta;
                    end else if (moving_tick) begin
                        remain_r <= remain_r - step;
                        if (remain_r == step) begin
                            move_state_r <= PLA_MV_IDLE;
                        end
                    end
                end
                default: begin
                    move_state_r <= PLA_MV_IDLE;
                end
            endcase
        end
    end

    // position loop: error on linear values, proportional gain only
    logic pos_mode; // loop enabled by the mode selector
    logic signed [POS_W-1:0] err_nxt; // fresh position error
    logic signed [POS_W+KP_W:0] vel_prod; // gain times error
    logic [POS_W-1:0] err_abs; // magnitude of held error
    logic fault_set; // excess error seen this cycle
    assign pos_mode = (operating_mode_select == OPMODE_POSITION);
    assign err_nxt = cmd_lin_r - fb_lin_r;
    assign vel_prod = err_nxt * $signed({1'b0, position_prop_gain});
    assign err_abs = position_error_value[POS_W-1]
                   ? -position_error_value : position_error_value;
    assign fault_set = pos_mode && (max_following_error != 0)
                     && (err_abs > max_following_error);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            position_error_value <= POS_RESET;
            velocity_command <= POS_RESET;
            following_error_fault <= 1'b0;
        end else begin
            if (!pos_mode) begin
                velocity_command <= POS_RESET;
            end else if (tick) begin
                position_error_value <= err_nxt;
                velocity_command <= vel_prod[KP_SHIFT +: POS_W];
            end
            // a new excess wins over a clear in the same cycle
            following_error_fault <= fault_set
                || (following_error_fault && !following_error_clear);
        end
    end

    // capture engines latch the reported actual position
    logic signed [POS_W-1:0] cap_r [2]; // captured positions
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cap
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    cap_r[gi] <= POS_RESET;
                end else if (capture_trigger[gi]) begin
                    cap_r[gi] <= act_disp;
                end
            end
        end
    endgenerate
    assign capture_a_position = cap_r[0];
    assign capture_b_position = cap_r[1];

    // programmable limit flags; a window with an end outside the modulo
    // range stays off, which keeps a stale window from firing
    generate
        for (gi = 0; gi < NUM_PLS; gi++) begin : g_pls
            logic signed [POS_W-1:0] lo_w; // window low end
            logic signed [POS_W-1:0] hi_w; // window high end
            logic win_ok; // window usable in modulo space
            assign lo_w = pls_low[gi*POS_W +: POS_W];
            assign hi_w = pls_high[gi*POS_W +: POS_W];
            assign win_ok = in_mod(lo_w, range_lo, range_hi, mod_active)
                         && in_mod(hi_w, range_lo, range_hi,
                                   mod_active);
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    pls_flag[gi] <= 1'b0;
                end else begin
                    pls_flag[gi] <= win_ok && act_settled
                        && act_disp >= lo_w && act_disp <= hi_w;
                end
            end
        end
    endgenerate

    // threshold outputs; the compared position is not gated on act_settled,
    // so an out-of-range threshold leaves the output constant only once it is folded
    generate
        for (gi = 0; gi < NUM_DOUT; gi++) begin : g_dout
            logic [3:0] mode_w; // output mode
            logic signed [POS_W-1:0] thr_w; // threshold
            assign mode_w = dout_mode[gi*4 +: 4];
            assign thr_w = dout_threshold[gi*POS_W +: POS_W];
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    dout_level[gi] <= 1'b0;
                end else if (mode_w == DOUT_MODE_ABOVE) begin
                    dout_level[gi] <= act_disp > thr_w;
                end else if (mode_w == DOUT_MODE_BELOW) begin
                    dout_level[gi] <= act_disp < thr_w;
                end else begin
                    dout_level[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // checks on the design's own outputs
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_bad_target;
        move_start && target_bad;
    endsequence

    a_loop_mode_gate: assert property (
        !pos_mode |=> velocity_command == 0)
        else $error("velocity command not zero outside position mode");
    a_fault_raise: assert property (
        fault_set |=> following_error_fault)
        else $error("following error fault not raised");
    a_fault_zero_max: assert property (
        (max_following_error == 0 && following_error_clear)
        |=> !following_error_fault)
        else $error("fault raised with zero error limit");
    a_error_calc: assert property (
        (tick && pos_mode)
        |=> position_error_value == $past(cmd_lin_r) - $past(fb_lin_r))
        else $error("position error is not command minus feedback");
    a_wrap_range: assert property (
        (mod_active && act_settled && !fb_load)
        |=> (actual_position >= $past(range_lo)
             && actual_position < $past(range_hi)))
        else $error("actual position left the modulo range");
    a_capture_mod: assert property (
        capture_trigger[0] |=> capture_a_position == $past(act_disp))
        else $error("capture does not hold reported position");
    a_target_warn: assert property (
        s_bad_target |=> move_target_warning ##1 !move_target_warning
                         || $past(move_start))
        else $error("no warning for out-of-range target");
    a_limit_stop: assert property (
        lim_hit |=> !move_busy)
        else $error("motion not stopped at software limit");
    a_pls_window: assert property (
        !g_pls[1].win_ok |=> !pls_flag[1])
        else $error("limit flag active with window out of range");

endmodule : pla_position_loop

// >>> verif/pla_far_model.sv
// far side: multiturn feedback device and motion command source
// assumes the bench calls its tasks; signals change on falling edges
`timescale 1ns/1ps
module pla_far_model
    import pla_pkg::*;
(
    input wire logic clock,
    output logic feedback_valid,
    output logic signed [POS_W-1:0] feedback_position,
    output logic move_start,
    output logic signed [POS_W-1:0] move_target
);
    initial begin
        feedback_valid = 1'b0;
        feedback_position = 32'h0000_0000;
        move_start = 1'b0;
        move_target = 32'h0000_0000;
    end
    // one feedback word; line shows junk once released so stale data hurts
    task send_fb(input logic signed [POS_W-1:0] v);
        @(negedge clock);
        feedback_valid = 1'b1;
        feedback_position = v;
        @(negedge clock);
        feedback_valid = 1'b0;
        feedback_position = ~v;
    endtask : send_fb
    // absolute target, already in modulo form when modulo is on
    task send_move(input logic signed [POS_W-1:0] t);
        @(negedge clock);
        move_start = 1'b1;
        move_target = t;
        @(negedge clock);
        move_start = 1'b0;
        move_target = ~t;
    endtask : send_move
endmodule : pla_far_model

// >>> verif/pla_position_loop_test.sv
// self-checking bench for the position loop with modulo axis
// assumes a short loop tick (4 cycles) to keep the run brief
`timescale 1ns/1ps
module pla_position_loop_test;
    import pla_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, fclr = 1'b0, men = 1'b0;
    logic [3:0] mode = 4'h0;
    logic [KP_W-1:0] kp = 16'h0100; // gain of one
    logic [POS_W-2:0] stp = 31'h64; // step limit per tick
    logic [POS_W-1:0] lim = 32'h0;
    logic signed [POS_W-1:0] ba = 32'h0, bb = 32'h0, slp = 32'h0, sln = 32'h0;
    logic [1:0] dir = 2'h0, cap = 2'h0;
    logic [127:0] plo = 128'h0, phi = 128'h0;
    logic [7:0] dmode = 8'h00;
    logic [63:0] dthr = 64'h0;
    logic fv, ms, busy, warn, hit, ldd, flt;
    logic signed [POS_W-1:0] fp, mt, cmd, act, err, vel, ca, cb;
    logic [3:0] pls;
    logic [1:0] dl;
    int bad_count = 0, checked = 0, cyc = 0;
    logic signed [POS_W-1:0] tgt [4] = '{32'd20, 32'd900, 32'd500, 32'd30};
    always #4 clock = ~clock;
    pla_far_model far (.clock(clock), .feedback_valid(fv),
        .feedback_position(fp), .move_start(ms), .move_target(mt));
    pla_position_loop #(.LOOP_DIV(4)) dut (.clock(clock), .rst_n(rst_n),
        .operating_mode_select(mode), .position_prop_gain(kp),
        .max_following_error(lim), .following_error_clear(fclr),
        .modulo_enable(men), .modulo_bound_a(ba), .modulo_bound_b(bb),
        .absolute_move_direction(dir), .feedback_position(fp),
        .feedback_valid(fv), .move_start(ms), .move_target(mt),
        .move_step(stp), .sw_limit_pos(slp), .sw_limit_neg(sln),
        .capture_trigger(cap), .pls_low(plo), .pls_high(phi),
        .dout_mode(dmode), .dout_threshold(dthr),
        .commanded_position(cmd), .actual_position(act),
        .position_error_value(err), .velocity_command(vel),
        .capture_a_position(ca), .capture_b_position(cb),
        .following_error_fault(flt), .move_target_warning(warn),
        .move_busy(busy), .sw_limit_hit(hit), .position_loaded(ldd),
        .pls_flag(pls), .dout_level(dl));
    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset();
        @(negedge clock);
        rst_n = 1'b0;
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
    endtask : do_reset
    // linear loop: error, gain, fault and mode gating
    task automatic t_loop();
        do_reset();
        chk({ldd, flt, busy}, 32'h0);
        far.send_fb(32'd100);
        chk(ldd, 32'h1);
        chk(cmd, 32'd100);
        far.send_fb(32'd50);
        mode = OPMODE_POSITION;
        lim = 32'd10;
        repeat (16) @(negedge clock);
        chk(err, 32'd50);
        chk(vel, 32'd50);
        chk(act, 32'd50);
        chk(flt, 32'h1);
        kp = 16'h0200; // gain of two
        repeat (8) @(negedge clock);
        chk(vel, 32'd100);
        lim = 32'h0;
        fclr = 1'b1;
        @(negedge clock);
        fclr = 1'b0;
        repeat (16) @(negedge clock);
        chk(flt, 32'h0);
        mode = 4'h1;
        repeat (2) @(negedge clock);
        chk(vel, 32'h0);
    endtask : t_loop
    // modulo view: reporting, captures, limits, flags and outputs
    task automatic t_mod();
        do_reset();
        men = 1'b1;
        ba = 32'd1000; // higher bound given first
        sln = -32'sd5000;
        slp = 32'd5000;
        far.send_fb(32'd1005);
        repeat (5) @(negedge clock);
        chk(act, 32'd5);
        chk(cmd, 32'd5);
        chk(hit, 32'h0);
        cap = 2'b11;
        @(negedge clock);
        cap = 2'b00;
        plo = {32'd6, 32'd6, 32'd2000, 32'd0};
        phi = {32'd9, 32'd9, 32'd2100, 32'd10};
        dmode = {4'h6, 4'h5};
        dthr = {32'd5000, 32'd3};
        repeat (3) @(negedge clock);
        chk(ca, 32'd5);
        chk(cb, 32'd5);
        chk(pls, 32'h1);
        chk(dl, 32'h3);
        dmode = {4'h5, 4'h6};
        repeat (3) @(negedge clock);
        chk(dl, 32'h0);
        slp = 32'd3;
        repeat (3) @(negedge clock);
        chk(hit, 32'h1);
        slp = 32'd5000;
        repeat (3) @(negedge clock);
        ba = 32'd0; // same range, lower bound given first now
        bb = 32'd1000;
        @(negedge clock);
        chk(act, 32'd5);
    endtask : t_mod
    // absolute moves in modulo space, bad target and all four directions
    task automatic t_moves();
        int n;
        stp = 31'h32; // step of 50 per tick
        far.send_move(32'd2000);
        chk({warn, busy}, 32'h2);
        for (int d = 0; d < 4; d++) begin
            dir = d[1:0];
            far.send_move(tgt[d]);
            for (n = 0; n < 400 && busy; n++) @(negedge clock);
            repeat (3) @(negedge clock);
            chk(cmd, tgt[d]);
            // shortest way is 400 at 50 per tick: 8 ticks, 29 to 32 cycles
            if (d == 2) chk({31'h0, n >= 29 && n <= 32}, 32'h1);
        end
    endtask : t_moves
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    initial begin
        t_loop();
        t_mod();
        t_moves();
        summarize();
    end
endmodule : pla_position_loop_test
